// file: sbl_pkg.sv
// Shared constants and types for the S-bus line coding and multiframe logic.
// Assumes a single 20 MHz clock domain and a recovered bit strobe from the line.
package sbl_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int FRAME_RATE_HZ = 4000;
  localparam int FRAME_PERIOD_NS = 1000000000 / FRAME_RATE_HZ;
  localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LOS_FRAMES = 2;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int FRAME_BITS = 48;
  localparam int BPOS_W = 6;
  localparam logic [BPOS_W-1:0] POS_FRAMING = 6'h00;
  localparam logic [BPOS_W-1:0] POS_LAST = 6'h2f;
  localparam logic [BPOS_W-1:0] RX_FA_POS = 6'h0c;
  localparam logic [BPOS_W-1:0] RX_M_POS = 6'h18;
  localparam logic [BPOS_W-1:0] RX_S_POS = 6'h23;
  localparam logic [BPOS_W-1:0] RX_E_POS0 = 6'h0a;
  localparam logic [BPOS_W-1:0] RX_E_POS1 = 6'h16;
  localparam logic [BPOS_W-1:0] RX_E_POS2 = 6'h21;
  localparam logic [BPOS_W-1:0] RX_E_POS3 = 6'h2c;
  localparam logic [BPOS_W-1:0] TX_D_POS0 = 6'h0b;
  localparam logic [BPOS_W-1:0] TX_D_POS1 = 6'h17;
  localparam logic [BPOS_W-1:0] TX_D_POS2 = 6'h22;
  localparam logic [BPOS_W-1:0] TX_D_POS3 = 6'h2d;
  localparam logic [BPOS_W-1:0] TX_Q_POS = 6'h0d;
  localparam logic [1:0] SIG_MIN_MARKS = 2'h3;

  // ****************************************
  // Multiframe
  // ****************************************
  localparam int MF_IDX_W = 5;
  localparam logic [MF_IDX_W-1:0] MF_IDX_LAST = 5'h13;
  localparam logic [1:0] MF_NEED = 2'h3;
  localparam int MF_EN_BIT = 0;
  localparam int MF_FIRST_BIT = 4;
  localparam int MF_SYNC_BIT = 7;
  localparam int SB_CHANGE_BIT = 7;
  localparam int SB_AVAIL_BIT = 5;
  localparam int QB_IDLE_BIT = 4;

  // ****************************************
  // Receive buffer
  // ****************************************
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;

  typedef enum logic [1:0] {SBL_HUNT, SBL_CONFIRM, SBL_SYNCED} sbl_mf_state_t;

endpackage

// file: sbl_stream_if.sv
// Valid/ready stream carrier between the line logic and its receive buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface sbl_stream_if #(
  parameter int W = 8
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (
    output valid,
    output data,
    input ready
  );

  modport snk (
    input valid,
    input data,
    output ready
  );
endinterface

// file: sbl_fifo.sv
// Small receive FIFO with a registered read port.
// Assumes one clock; depth must be a power of two.
`timescale 1ns/100ps
module sbl_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic srst,
  sbl_stream_if.snk wr,
  sbl_stream_if.src rd
);

  localparam int AW = $clog2(D);

  generate
    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
      $error("sbl_fifo depth must be a power of two");
    end
  endgenerate

  logic [W-1:0] mem_ff [D];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic out_valid_ff;
  logic [W-1:0] out_data_ff;

  wire mem_empty = (wr_ptr_ff == rd_ptr_ff);
  wire mem_full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  wire do_push = wr.valid && !mem_full;
  wire do_load = !mem_empty && (!out_valid_ff || rd.ready);

  assign wr.ready = !mem_full;
  assign rd.valid = out_valid_ff;
  assign rd.data = out_data_ff;

  // Storage has no reset; the pointers and the output register carry the state.
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_load) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
        out_data_ff <= mem_ff[rd_ptr_ff[AW-1:0]];
        out_valid_ff <= 1'b1;
      end else if (rd.ready) begin
        out_valid_ff <= 1'b0;
      end
    end
  end

  fifo_no_overflow_a: assert property (@(posedge clk) disable iff (srst)
    mem_full |=> (wr_ptr_ff - rd_ptr_ff) <= (AW+1)'(D))
    else $error("fifo pointer distance exceeds depth");

endmodule

// file: sbl_line_interface_unit.sv
// Pseudo-ternary line coder, frame recovery and multiframe alignment.
// Assumes mark comparators and the recovered bit clock arrive asynchronously on pins.
`timescale 1ns/100ps

// Overview of operation
// - Binary one is a space on the line
// - Binary zeros alternate high and low marks
// - Same-polarity successive marks flag code violation
// - Violations realign the frame bit counter
// - Signal present needs three marks per frame
// - Frames are 48 bits in both directions
// - Frames repeat at 4 kHz
// - Decode to binary; compare E with D
// - Monitor framing only when enabled and F6/F7
// - Three good multiframes set synced and change
// - S-bit delivery starts at the second multiframe after sync
// - Q and S timed to received frames
// - Twenty frames; F_A every fifth, M first
// - Lose sync on three bad, state, disable
module sbl_line_interface_unit
  import sbl_pkg::*;
#(
  parameter int LOS_CYCLES = LOS_FRAMES * FRAME_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic rx_mark_hi,
  input wire logic rx_mark_lo,
  input wire logic rx_bit_clk,
  output logic tx_mark_hi,
  output logic tx_mark_lo,
  input wire logic tx_bit,
  input wire logic tx_d_bit,
  output logic tx_take,
  output logic [BPOS_W-1:0] tx_pos,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [FIFO_W-1:0] rx_data,
  output logic rx_overrun,
  output logic code_violation,
  output logic frame_lock,
  output logic any_signal,
  output logic collision,
  input wire logic in_synchronized_line_state,
  input wire logic in_activated_line_state,
  input wire logic [7:0] multiframe_control_register,
  input wire logic [4:0] multiframe_qbit_buffer,
  input wire logic sbuf_read,
  output logic [7:0] mf_status,
  output logic [7:0] multiframe_sbit_status_buffer
);

  // ****************************************
  // Checks and helpers
  // ****************************************
  localparam int LOS_W = $clog2(LOS_CYCLES + 1);

  generate
    if (LOS_CYCLES < 2) begin : g_bad_los
      $error("LOS_CYCLES too small");
    end
  endgenerate

  function automatic logic fa_expected(input logic [MF_IDX_W-1:0] idx);
    return (idx == 5'h00) || (idx == 5'h05) || (idx == 5'h0a) || (idx == 5'h0f);
  endfunction

  function automatic logic group_last(input logic [MF_IDX_W-1:0] idx);
    return (idx == 5'h04) || (idx == 5'h09) || (idx == 5'h0e) || (idx == MF_IDX_LAST);
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic hi_s1_ff, hi_s2_ff, lo_s1_ff, lo_s2_ff;
  logic bclk_s1_ff, bclk_s2_ff, bclk_s3_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      hi_s1_ff <= 1'b0;
      hi_s2_ff <= 1'b0;
      lo_s1_ff <= 1'b0;
      lo_s2_ff <= 1'b0;
      bclk_s1_ff <= 1'b0;
      bclk_s2_ff <= 1'b0;
      bclk_s3_ff <= 1'b0;
    end else begin
      hi_s1_ff <= rx_mark_hi;
      hi_s2_ff <= hi_s1_ff;
      lo_s1_ff <= rx_mark_lo;
      lo_s2_ff <= lo_s1_ff;
      bclk_s1_ff <= rx_bit_clk;
      bclk_s2_ff <= bclk_s1_ff;
      bclk_s3_ff <= bclk_s2_ff;
    end
  end

  // ****************************************
  // Receive decoding and frame recovery
  // ****************************************
  logic last_pol_ff, have_mark_ff;
  logic [BPOS_W-1:0] bitpos_ff;
  logic frame_lock_ff, code_viol_ff, any_signal_ff, collision_ff, overrun_ff;
  logic [1:0] mark_cnt_ff;
  logic [LOS_W-1:0] los_cnt_ff;
  logic fa_ff, m_ff, s_ff, d_sent_ff;

  wire bit_stb = bclk_s2_ff && !bclk_s3_ff;
  wire rx_mark = hi_s2_ff || lo_s2_ff;
  wire rx_pol = hi_s2_ff;
  wire rx_bit = !rx_mark;
  wire code_viol = bit_stb && rx_mark && have_mark_ff && (rx_pol == last_pol_ff);
  wire [BPOS_W-1:0] cur_pos = code_viol ? POS_FRAMING : bitpos_ff;
  wire [BPOS_W-1:0] nxt_bitpos = (cur_pos == POS_LAST) ? POS_FRAMING : cur_pos + 6'h01;
  wire frame_end = bit_stb && (cur_pos == POS_LAST);
  wire [1:0] nxt_mark_cnt = (rx_mark && mark_cnt_ff != SIG_MIN_MARKS) ? mark_cnt_ff + 2'h1 : mark_cnt_ff;
  wire is_e_pos = (cur_pos == RX_E_POS0) || (cur_pos == RX_E_POS1) || (cur_pos == RX_E_POS2)
                  || (cur_pos == RX_E_POS3);
  wire is_d_pos = (cur_pos == TX_D_POS0) || (cur_pos == TX_D_POS1) || (cur_pos == TX_D_POS2)
                  || (cur_pos == TX_D_POS3);
  wire los_expired = (los_cnt_ff == LOS_W'(LOS_CYCLES));

  always_ff @(posedge clk) begin
    if (srst) begin
      last_pol_ff <= 1'b0;
      have_mark_ff <= 1'b0;
      bitpos_ff <= POS_FRAMING;
      code_viol_ff <= 1'b0;
      frame_lock_ff <= 1'b0;
      los_cnt_ff <= '0;
    end else begin
      code_viol_ff <= code_viol;
      los_cnt_ff <= code_viol ? '0 : (los_expired ? los_cnt_ff : los_cnt_ff + 1'b1);
      if (bit_stb) begin
        bitpos_ff <= nxt_bitpos;
        if (rx_mark) begin
          last_pol_ff <= rx_pol;
          have_mark_ff <= 1'b1;
        end
      end
      // Lock needs a violation exactly where the counter expects a frame start.
      if (code_viol) begin
        frame_lock_ff <= (bitpos_ff == POS_FRAMING);
      end else if (los_expired) begin
        frame_lock_ff <= 1'b0;
      end
    end
  end

  // Frame-level sampling of marks, framing bits and echo bits.
  always_ff @(posedge clk) begin
    if (srst) begin
      mark_cnt_ff <= 2'h0;
      any_signal_ff <= 1'b0;
      fa_ff <= 1'b0;
      m_ff <= 1'b0;
      s_ff <= 1'b0;
      collision_ff <= 1'b0;
    end else begin
      collision_ff <= bit_stb && is_e_pos && (rx_bit != d_sent_ff);
      if (bit_stb) begin
        mark_cnt_ff <= frame_end ? 2'h0 : nxt_mark_cnt;
        if (frame_end) begin
          any_signal_ff <= (nxt_mark_cnt == SIG_MIN_MARKS);
        end
        if (cur_pos == RX_FA_POS) begin
          fa_ff <= rx_bit;
        end
        if (cur_pos == RX_M_POS) begin
          m_ff <= rx_bit;
        end
        if (cur_pos == RX_S_POS) begin
          s_ff <= rx_bit;
        end
      end
    end
  end

  // ****************************************
  // Multiframe alignment
  // ****************************************
  sbl_mf_state_t state_ff;
  logic [MF_IDX_W-1:0] mf_idx_ff;
  logic [1:0] good_cnt_ff, bad_cnt_ff;
  logic mf_bad_ff, change_ff, s_active_ff, s_avail_ff, s_first_ff;
  logic [4:0] s_shift_ff, s_word_ff;

  wire mon_en = multiframe_control_register[MF_EN_BIT] && frame_lock_ff
                && (in_synchronized_line_state || in_activated_line_state);
  wire synced = (state_ff == SBL_SYNCED);
  wire idx_last = (mf_idx_ff == MF_IDX_LAST);
  wire [MF_IDX_W-1:0] nxt_idx = idx_last ? 5'h00 : mf_idx_ff + 5'h01;
  wire frame_ok = (fa_ff == fa_expected(mf_idx_ff)) && (m_ff == (mf_idx_ff == 5'h00));
  wire mf_good = !mf_bad_ff && frame_ok;
  wire gain_sync = (state_ff == SBL_CONFIRM) && frame_end && idx_last && mf_good
                   && (good_cnt_ff == MF_NEED - 2'h1);
  wire lose_sync = synced && (!mon_en || (frame_end && idx_last && !mf_good && bad_cnt_ff == MF_NEED - 2'h1));
  wire s_word_done = s_active_ff && frame_end && group_last(mf_idx_ff);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= SBL_HUNT;
      mf_idx_ff <= 5'h00;
      good_cnt_ff <= 2'h0;
      bad_cnt_ff <= 2'h0;
      mf_bad_ff <= 1'b0;
    end else if (!mon_en) begin
      state_ff <= SBL_HUNT;
      good_cnt_ff <= 2'h0;
      bad_cnt_ff <= 2'h0;
    end else if (frame_end) begin
      mf_idx_ff <= nxt_idx;
      mf_bad_ff <= idx_last ? 1'b0 : (mf_bad_ff || !frame_ok);
      unique case (state_ff)
        SBL_HUNT: begin
          if (fa_ff && m_ff) begin
            state_ff <= SBL_CONFIRM;
            mf_idx_ff <= 5'h01;
            mf_bad_ff <= 1'b0;
            good_cnt_ff <= 2'h0;
          end
        end
        SBL_CONFIRM: begin
          if (idx_last && mf_good) begin
            good_cnt_ff <= good_cnt_ff + 2'h1;
            if (gain_sync) begin
              state_ff <= SBL_SYNCED;
              bad_cnt_ff <= 2'h0;
            end
          end else if (idx_last) begin
            state_ff <= SBL_HUNT;
            good_cnt_ff <= 2'h0;
          end
        end
        SBL_SYNCED: begin
          if (idx_last) begin
            bad_cnt_ff <= mf_good ? 2'h0 : bad_cnt_ff + 2'h1;
            if (lose_sync) begin
              state_ff <= SBL_HUNT;
              good_cnt_ff <= 2'h0;
            end
          end
        end
      endcase
    end
  end

  // Change flag and S-bit handoff; a new event beats a read in the same cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      change_ff <= 1'b0;
      s_active_ff <= 1'b0;
      s_avail_ff <= 1'b0;
      s_first_ff <= 1'b0;
      s_shift_ff <= 5'h00;
      s_word_ff <= 5'h00;
    end else begin
      if (gain_sync || lose_sync) begin
        change_ff <= 1'b1;
      end else if (sbuf_read) begin
        change_ff <= 1'b0;
      end
      if (!synced || lose_sync) begin
        s_active_ff <= 1'b0;
      end else if (frame_end && idx_last) begin
        s_active_ff <= 1'b1;
      end
      if (s_active_ff && frame_end) begin
        s_shift_ff <= {s_shift_ff[3:0], s_ff};
      end
      if (s_word_done) begin
        s_word_ff <= {s_shift_ff[3:0], s_ff};
        s_first_ff <= (mf_idx_ff == 5'h04);
        s_avail_ff <= 1'b1;
      end else if (sbuf_read) begin
        s_avail_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Transmit encoder
  // ****************************************
  logic tx_pol_ff, tx_hi_ff, tx_lo_ff, tx_take_ff;
  logic [BPOS_W-1:0] tx_pos_ff;

  // Q bits only follow the multiframe once S-bit delivery is active; otherwise the idle value goes in every Q slot.
  wire [1:0] q_sel = (mf_idx_ff >= 5'h0f) ? 2'h3 : (mf_idx_ff >= 5'h0a) ? 2'h2 : (mf_idx_ff >= 5'h05) ? 2'h1 : 2'h0;
  wire q_val = s_active_ff ? (fa_expected(mf_idx_ff) && multiframe_qbit_buffer[q_sel])
                           : multiframe_qbit_buffer[QB_IDLE_BIT];
  wire tx_val = (cur_pos == POS_FRAMING) ? 1'b0 : (cur_pos == TX_Q_POS) ? q_val : is_d_pos ? tx_d_bit : tx_bit;
  // The framing mark repeats the previous polarity so the far end sees a violation.
  wire tx_mark_pol = (cur_pos == POS_FRAMING) ? tx_pol_ff : !tx_pol_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_pol_ff <= 1'b0;
      tx_hi_ff <= 1'b0;
      tx_lo_ff <= 1'b0;
      tx_take_ff <= 1'b0;
      tx_pos_ff <= POS_FRAMING;
      d_sent_ff <= 1'b1;
    end else begin
      tx_take_ff <= bit_stb;
      if (bit_stb) begin
        tx_pos_ff <= cur_pos;
        tx_hi_ff <= !tx_val && tx_mark_pol;
        tx_lo_ff <= !tx_val && !tx_mark_pol;
        if (!tx_val) begin
          tx_pol_ff <= tx_mark_pol;
        end
        if (is_d_pos) begin
          d_sent_ff <= tx_d_bit;
        end
      end
    end
  end

  // ****************************************
  // Receive buffer
  // ****************************************
  sbl_stream_if #(.W(FIFO_W)) push_if ();
  sbl_stream_if #(.W(FIFO_W)) pop_if ();

  assign push_if.valid = bit_stb;
  assign push_if.data = {frame_lock_ff, cur_pos, rx_bit};

  always_ff @(posedge clk) begin
    if (srst) begin
      overrun_ff <= 1'b0;
    end else begin
      overrun_ff <= bit_stb && !push_if.ready;
    end
  end

  sbl_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk(clk),
    .srst(srst),
    .wr(push_if.snk),
    .rd(pop_if.src)
  );

  assign pop_if.ready = rx_ready;
  assign rx_valid = pop_if.valid;
  assign rx_data = pop_if.data;
  assign rx_overrun = overrun_ff;
  assign tx_mark_hi = tx_hi_ff;
  assign tx_mark_lo = tx_lo_ff;
  assign tx_take = tx_take_ff;
  assign tx_pos = tx_pos_ff;
  assign code_violation = code_viol_ff;
  assign frame_lock = frame_lock_ff;
  assign any_signal = any_signal_ff;
  assign collision = collision_ff;
  assign mf_status = {synced, 2'h0, s_first_ff, 3'h0, multiframe_control_register[MF_EN_BIT]};
  assign multiframe_sbit_status_buffer = {change_ff, 1'b0, s_avail_ff, s_word_ff};

  // ****************************************
  // Assertions
  // ****************************************
  viol_flag_a: assert property (@(posedge clk) disable iff (srst)
    (bit_stb && rx_mark && have_mark_ff && rx_pol == last_pol_ff) |=> code_violation)
    else $error("same-polarity mark pair not flagged");

  viol_align_a: assert property (@(posedge clk) disable iff (srst)
    code_viol |=> bitpos_ff == 6'h01)
    else $error("bit counter not realigned on violation");

  pos_range_a: assert property (@(posedge clk) disable iff (srst)
    bitpos_ff <= POS_LAST)
    else $error("bit position beyond frame length");

  one_space_a: assert property (@(posedge clk) disable iff (srst)
    (bit_stb && tx_val) |=> !tx_mark_hi && !tx_mark_lo)
    else $error("binary one not sent as space");

  zero_alt_a: assert property (@(posedge clk) disable iff (srst)
    (bit_stb && !tx_val && cur_pos != POS_FRAMING) |=> (tx_mark_hi != $past(tx_pol_ff)) && (tx_mark_hi != tx_mark_lo))
    else $error("zero mark did not alternate");

  signal_min_a: assert property (@(posedge clk) disable iff (srst)
    (frame_end && mark_cnt_ff == 2'h0) |=> !any_signal)
    else $error("signal reported with too few marks");

  mon_gate_a: assert property (@(posedge clk) disable iff (srst)
    !mon_en |=> state_ff == SBL_HUNT && !mf_status[MF_SYNC_BIT])
    else $error("alignment kept while monitoring disabled");

  sync_gain_a: assert property (@(posedge clk) disable iff (srst)
    gain_sync && mon_en |=> mf_status[MF_SYNC_BIT] && multiframe_sbit_status_buffer[SB_CHANGE_BIT])
    else $error("sync or change flag missing after three multiframes");

  sdeliver_a: assert property (@(posedge clk) disable iff (srst)
    $rose(s_active_ff) |-> mf_idx_ff == 5'h00)
    else $error("S-bit delivery did not start at multiframe boundary");

  sync_loss_a: assert property (@(posedge clk) disable iff (srst)
    lose_sync |=> !mf_status[MF_SYNC_BIT] && multiframe_sbit_status_buffer[SB_CHANGE_BIT] && !s_active_ff)
    else $error("loss of alignment not reported");

  reset_clear_a: assert property (@(posedge clk)
    srst |=> !mf_status[MF_SYNC_BIT] && good_cnt_ff == 2'h0)
    else $error("alignment state not cleared by reset");

  echo_cmp_a: assert property (@(posedge clk) disable iff (srst)
    (bit_stb && is_e_pos && rx_bit == d_sent_ff) |=> !collision)
    else $error("collision flagged on matching echo");

endmodule

// file: sbl_nt_model.sv
// Network-side line model: sends framed pseudo-ternary bits and echoes D bits back on E.
// Assumes it shares the bench clock; its bit clock runs free, as on a live line.
`timescale 1ns/100ps
module sbl_nt_model
  import sbl_pkg::*;
#(
  parameter int BC = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic tx_mark_hi,
  input wire logic tx_mark_lo,
  input wire logic [1:0] quiet_marks,
  input wire logic bad_mf,
  input wire logic e_flip,
  output logic rx_mark_hi,
  output logic rx_mark_lo,
  output logic rx_bit_clk
);
  int cnt_ff;
  logic [5:0] pos_ff;
  logic [4:0] frm_ff;
  logic pol_ff;
  logic last_d_ff;
  logic wrap;
  logic [5:0] nxt_pos;
  logic [4:0] nxt_frm;
  logic nxt_bit;
  assign wrap = pos_ff == POS_LAST;
  assign nxt_pos = wrap ? POS_FRAMING : pos_ff + 6'h01;
  assign nxt_frm = !wrap ? frm_ff : (frm_ff == MF_IDX_LAST) ? 5'h00 : frm_ff + 5'h01;
  always_comb begin
    nxt_bit = nxt_pos[0];
    if (quiet_marks != 2'h0) begin
      nxt_bit = nxt_pos >= {4'h0, quiet_marks};
    end else if (nxt_pos == RX_FA_POS) begin
      nxt_bit = (nxt_frm % 5'h05 == 5'h00) && !(bad_mf && nxt_frm == 5'h00);
    end else if (nxt_pos == RX_M_POS) begin
      nxt_bit = nxt_frm == 5'h00;
    end else if (nxt_pos inside {RX_E_POS0, RX_E_POS1, RX_E_POS2, RX_E_POS3}) begin
      nxt_bit = last_d_ff ^ e_flip;
    end
  end
  // The tx marks lag the bit clock by a few cycles, so they are read one bit later, at the next bit clock rise.
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff <= 0;
      pos_ff <= POS_LAST;
      frm_ff <= MF_IDX_LAST;
      pol_ff <= 1'b0;
      last_d_ff <= 1'b1;
      rx_mark_hi <= 1'b0;
      rx_mark_lo <= 1'b0;
      rx_bit_clk <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff == BC - 1) ? 0 : cnt_ff + 1;
      if (cnt_ff == 0) begin
        pos_ff <= nxt_pos;
        frm_ff <= nxt_frm;
        rx_bit_clk <= 1'b0;
        rx_mark_hi <= !nxt_bit && (nxt_pos == POS_FRAMING ? pol_ff : !pol_ff);
        rx_mark_lo <= !nxt_bit && (nxt_pos == POS_FRAMING ? !pol_ff : pol_ff);
        if (!nxt_bit && nxt_pos != POS_FRAMING) begin
          pol_ff <= !pol_ff;
        end
      end
      if (cnt_ff == BC / 2) begin
        rx_bit_clk <= 1'b1;
        if ((pos_ff - 6'h01) inside {TX_D_POS0, TX_D_POS1, TX_D_POS2, TX_D_POS3}) begin
          last_d_ff <= !(tx_mark_hi || tx_mark_lo);
        end
      end
    end
  end
endmodule

// file: tb_top.sv
// Self-checking bench for the line interface unit facing the network-side line model.
// Assumes the package, stream interface, FIFO, unit and model files are compiled first.
`timescale 1ns/100ps
module tb_top;
  import sbl_pkg::*;
  localparam int BC = 8;
  localparam int FR = FRAME_BITS * BC;
  localparam int MFC = FR * 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic mh, ml, bclk, txh, txl, tx_take, rx_valid, rx_overrun, cv, lock, any_sig, coll;
  logic [5:0] tx_pos;
  logic [7:0] rx_data, mf_status, sbuf;
  logic tx_bit = 1'b1, tx_d_bit = 1'b1, rx_ready = 1'b1, st6 = 1'b0, st7 = 1'b0;
  logic sbuf_read = 1'b0, bad = 1'b0, eflip = 1'b0, last_hi = 1'b0, rx_on = 1'b1;
  logic [7:0] mfc = 8'h01;
  logic [4:0] qb = 5'h10;
  logic [1:0] quiet = 2'h0;
  logic [7:0] rnd = 8'h38;
  int failures = 0, compares = 0, cv_n = 0, coll_n = 0, ovr_n = 0, rdy_mode = 0, n;
  always #25 clk = ~clk;
  sbl_line_interface_unit #(.LOS_CYCLES(3 * FR)) u_dut (
    .clk(clk), .srst(srst), .rx_mark_hi(mh), .rx_mark_lo(ml), .rx_bit_clk(bclk),
    .tx_mark_hi(txh), .tx_mark_lo(txl), .tx_bit(tx_bit), .tx_d_bit(tx_d_bit), .tx_take(tx_take),
    .tx_pos(tx_pos), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_overrun(rx_overrun),
    .code_violation(cv), .frame_lock(lock), .any_signal(any_sig), .collision(coll),
    .in_synchronized_line_state(st6), .in_activated_line_state(st7), .multiframe_control_register(mfc),
    .multiframe_qbit_buffer(qb), .sbuf_read(sbuf_read), .mf_status(mf_status),
    .multiframe_sbit_status_buffer(sbuf));
  sbl_nt_model #(.BC(BC)) u_nt (
    .clk(clk), .srst(srst), .tx_mark_hi(txh), .tx_mark_lo(txl), .quiet_marks(quiet), .bad_mf(bad),
    .e_flip(eflip), .rx_mark_hi(mh), .rx_mark_lo(ml), .rx_bit_clk(bclk));
  function automatic logic [7:0] nxt_rnd(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic exp_tx(input logic [5:0] p);
    if (p inside {TX_D_POS0, TX_D_POS1, TX_D_POS2, TX_D_POS3}) return tx_d_bit;
    if (p == TX_Q_POS) return qb[4];
    return tx_bit;
  endfunction
  function automatic logic rx_free(input logic [5:0] p);
    return !(p inside {POS_FRAMING, RX_FA_POS, RX_M_POS, RX_E_POS0, RX_E_POS1, RX_E_POS2, RX_E_POS3});
  endfunction
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic step;
    @(negedge clk);
    n++;
  endtask
  // Ready is set before the pop is judged, since the pop lands on the next rising edge.
  always @(negedge clk) begin
    rnd = nxt_rnd(rnd);
    rx_ready = (rdy_mode == 0) | ((rdy_mode == 1) & rnd[0]);
    if (rx_valid === 1'b1 && rx_ready && rx_on && rx_data[7] === 1'b1 && rx_free(rx_data[6:1])) begin
      chk("rx bit", {7'h0, rx_data[1]}, {7'h0, rx_data[0]});
    end
    if (cv === 1'b1) cv_n++;
    if (coll === 1'b1) coll_n++;
    if (rx_overrun === 1'b1) ovr_n++;
    if (tx_take === 1'b1) begin
      if (lock === 1'b1 && tx_pos === POS_FRAMING) begin
        chk("violation mark", {6'h0, last_hi, ~last_hi}, {6'h0, txh, txl});
      end else if (lock === 1'b1 && (tx_pos !== TX_Q_POS || mf_status[7] === 1'b0)) begin
        if (exp_tx(tx_pos)) chk("space", 8'h00, {6'h0, txh, txl});
        else chk("mark", {6'h0, ~last_hi, last_hi}, {6'h0, txh, txl});
      end
      if (txh | txl) last_hi = txh;
      tx_bit = rnd[1];
      tx_d_bit = rnd[2];
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk("synced flag", 8'h0, {7'h0, mf_status[7]});
    chk("change flag", 8'h0, {7'h0, sbuf[7]});
    n = 0;
    while (lock !== 1'b1 && n < 4 * FR) step();
    chk("frame lock", 8'h1, {7'h0, lock});
    rdy_mode = 1;
    repeat (FR) @(negedge clk);
    cv_n = 0;
    coll_n = 0;
    repeat (4 * FR) @(negedge clk);
    chk("violations", 8'h4, cv_n[7:0]);
    chk("collisions", 8'h0, coll_n[7:0]);
    rdy_mode = 2;
    repeat (20 * BC) @(negedge clk);
    chk("fifo full", 8'h1, {7'h0, rx_valid});
    chk("overrun", 8'h1, {7'h0, ovr_n > 0});
    rdy_mode = 0;
    n = 0;
    while (rx_valid !== 1'b0 && n < 8 * BC) step();
    chk("fifo empty", 8'h0, {7'h0, rx_valid});
    coll_n = 0;
    eflip = 1'b1;
    repeat (2 * FR) @(negedge clk);
    eflip = 1'b0;
    repeat (FR) @(negedge clk);
    chk("collisions", 8'h8, coll_n[7:0]);
    rx_on = 1'b0;
    quiet = 2'h2;
    repeat (3 * FR) @(negedge clk);
    chk("two marks", 8'h0, {7'h0, any_sig});
    quiet = 2'h3;
    repeat (3 * FR) @(negedge clk);
    chk("three marks", 8'h1, {7'h0, any_sig});
    quiet = 2'h0;
    repeat (2 * MFC) @(negedge clk);
    chk("gated sync", 8'h0, {7'h0, mf_status[7]});
    st7 = 1'b1;
    n = 0;
    while (mf_status[7] !== 1'b1 && n < 5 * MFC) step();
    chk("synced", 8'h1, {7'h0, mf_status[7]});
    chk("sync time", 8'h1, {7'h0, n >= 2 * MFC});
    chk("change set", 8'h1, {7'h0, sbuf[7]});
    sbuf_read = 1'b1;
    @(negedge clk);
    sbuf_read = 1'b0;
    @(negedge clk);
    chk("change cleared", 8'h0, {7'h0, sbuf[7]});
    n = 0;
    while (sbuf[5] !== 1'b1 && n < 2 * MFC) step();
    chk("s word time", 8'h1, {7'h0, n >= 4 * FR && sbuf[5] === 1'b1});
    chk("s word", 8'h1f, {3'h0, sbuf[4:0]});
    chk("first word", 8'h1, {7'h0, mf_status[4]});
    bad = 1'b1;
    n = 0;
    while (mf_status[7] !== 1'b0 && n < 5 * MFC) step();
    chk("loss time", 8'h1, {7'h0, n >= 2 * MFC && n <= 4 * MFC + FR});
    chk("change on loss", 8'h1, {7'h0, sbuf[7]});
    report_and_stop();
  end
  // The limit covers about eleven multiframes of work with a margin.
  initial begin
    repeat (13 * MFC) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule
